// *** rtl/art_pkg.sv ***
// Register map, field layout and constants of the auto-reload PWM timer
package art_pkg;

    // ----------------------------------------------------------------
    // Register word indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_DUTY_CH1 = 8'h14;
    localparam logic [7:0] IDX_DUTY_CH0 = 8'h15;
    localparam logic [7:0] IDX_PWM_CTRL = 8'h16;
    localparam logic [7:0] IDX_TIMER_CSR = 8'h17;
    localparam logic [7:0] IDX_COUNTER = 8'h18;
    localparam logic [7:0] IDX_RELOAD = 8'h19;
    localparam logic [7:0] IDX_CAPTURE_CSR = 8'h1A;
    localparam logic [7:0] IDX_CAPTURE_1 = 8'h1B;
    localparam logic [7:0] IDX_CAPTURE_2 = 8'h1C;
    localparam logic [7:0] IDX_TB_COUNT = 8'h1D;
    localparam logic [7:0] IDX_TB_CSR = 8'h1E;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CSR_EXT_CLOCK_SELECT = 7;
    localparam int CSR_CC_LO = 4;
    localparam int CSR_CC_HI = 6;
    localparam int CSR_RUN = 3;
    localparam int CSR_FORCE = 2;
    localparam int CSR_OIE = 1;
    localparam int CSR_OVF = 0;
    localparam int PWM_OE_LO = 4;
    localparam int PWM_OE_HI = 5;
    localparam int PWM_POL_LO = 0;
    localparam int PWM_POL_HI = 1;
    localparam int CAP_EDGE_LO = 4;
    localparam int CAP_EDGE_HI = 5;
    localparam int CAP_IE_LO = 2;
    localparam int CAP_IE_HI = 3;
    localparam int CAP_FLAG_LO = 0;
    localparam int CAP_FLAG_HI = 1;
    localparam int TB_CHAIN = 6;
    localparam int TB_OVF = 5;
    localparam int TB_ITE = 4;
    localparam int TB_RUN = 3;
    localparam int TB_PR_LO = 0;
    localparam int TB_PR_HI = 2;

    // ----------------------------------------------------------------
    // Values
    // ----------------------------------------------------------------
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [7:0] BYTE_MAX = 8'hFF;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_ONE = 8'h01;
    localparam logic [6:0] ART_PRE_RESET = 7'h00;
    localparam logic [2:0] SYNC_RESET = 3'h0;
    localparam logic [3:0] TB_TAP_OFFSET = 4'h1;
    localparam logic [23:0] RD_PAD = 24'h000000;

endpackage

// *** rtl/art_timer.sv ***
// Auto-reload PWM timer with input capture, timebase unit and Wishbone slave
//
// Function
// RULE1: ext_clock_select picks CPU clock (0) or external clock (1) for prescaler.
// RULE2: Counter clock is prescaler input divided by two to counter_clock_divider.
// RULE3: counter_run_enable low freezes prescaler and counter; high lets them count.
// RULE4: Writing force_reload loads reload_value and clears prescaler; reads as zero.
// RULE5: Overflow request is overflow_flag and overflow_irq_enable.
// RULE6: Overflow_flag sets on FFh wrap to reload; clears on status read.
// RULE7: Counter register reads live count; writes load counter even while running.
// RULE8: Writing the counter register also clears the prescaler.
// RULE9: On overflow reload the counter and switch PWM outputs to polarity level.
// RULE10: reload_value sets PWM period and resolution; zero gives full eight bits.
// RULE11: Each pwm_output_enable bit connects its channel to its pin.
// RULE12: Output high while count at or below compare_shadow, low above; polarity inverts.
// RULE13: Polarity change inverts output at once.
// RULE14: Duty FFh holds output at 0, duty 00h holds it at 1.
// RULE15: Each duty_value sets its second edge; first edge is common overflow.
// RULE16: compare_shadow hidden; loaded from duty_value at each overflow.
// RULE17: capture_edge_select 0 triggers on falling edge, 1 on rising edge.
// RULE18: capture_irq_enable lets its capture_flag raise a request.
// RULE19: capture_flag sets on capture; clears on capture status read.
// RULE20: A capture latches the live counter into capture_value.
// RULE21: capture_value is frozen after capture until capture status is read.
// RULE22: timebase_run_enable resumes timebase counting at selected rate.
// RULE23: timebase_divider_select codes 000..111 divide by 2 up to 256.
// RULE24: Timebase wrap FFh to 00h sets flag; request when timebase_irq_enable.
// RULE25: Timebase count accepts writes at any time.
// RULE26: Chaining makes timebase the high byte clocked by the reload counter.
// RULE27: External clock and capture pins are synchronised to the CPU clock.
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none

module art_timer
    import art_pkg::*;
#(
    parameter int ADDR_WIDTH = 8
) (
    input wire logic CLOCK,
    input wire logic NRST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [ADDR_WIDTH-1:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic EXT_CLOCK_IN,
    input wire logic [1:0] CAPTURE_IN,
    output logic [1:0] PWM_OUT,
    output logic [1:0] PWM_OE,
    output logic ART_IRQ,
    output logic TB_IRQ
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // True when the low n bits of a prescaler are all ones
    function automatic logic tap_hit(input logic [7:0] pre, input logic [3:0] n);
        logic [7:0] mask;
        mask = 8'(({8'h00, BYTE_ONE} << n) - 16'h0001);
        return (pre & mask) == mask;
    endfunction

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0] duty [2];
    logic [7:0] pwm_ctrl;
    logic ext_clock_select;
    logic [2:0] counter_clock_divider;
    logic counter_run_enable;
    logic overflow_irq_enable;
    logic overflow_flag;
    logic [7:0] counter;
    logic [6:0] art_pre;
    logic [7:0] reload_value;
    logic [1:0] capture_edge_select;
    logic [1:0] capture_irq_enable;
    logic [1:0] capture_flag;
    logic [7:0] capture_value [2];
    logic [7:0] compare_shadow [2];
    logic [7:0] timebase_count;
    logic [7:0] tb_pre;
    logic chain_enable;
    logic timebase_ovf;
    logic timebase_irq_enable;
    logic timebase_run_enable;
    logic [2:0] timebase_divider_select;
    logic [2:0] ext_sync;
    logic ext_level;
    logic [2:0] cap_sync [2];
    logic [1:0] cap_level;

    // ----------------------------------------------------------------
    // Wishbone decode
    // ----------------------------------------------------------------
    // Registered ack: one wait state, then ack for exactly one cycle
    wire bus_req = WB_CYC_I & WB_STB_I;
    wire bus_fire = bus_req & WB_ACK_O;
    wire [ADDR_WIDTH-3:0] word_idx = WB_ADR_I[ADDR_WIDTH-1:2];
    wire [7:0] wdata = WB_DAT_I[7:0];
    wire wr_ok = bus_fire & WB_WE_I & WB_SEL_I[0];
    wire rd_ok = bus_fire & ~WB_WE_I;
    wire hit_duty1 = word_idx == (ADDR_WIDTH-2)'(IDX_DUTY_CH1);
    wire hit_duty0 = word_idx == (ADDR_WIDTH-2)'(IDX_DUTY_CH0);
    wire hit_pwm = word_idx == (ADDR_WIDTH-2)'(IDX_PWM_CTRL);
    wire hit_csr = word_idx == (ADDR_WIDTH-2)'(IDX_TIMER_CSR);
    wire hit_cnt = word_idx == (ADDR_WIDTH-2)'(IDX_COUNTER);
    wire hit_rel = word_idx == (ADDR_WIDTH-2)'(IDX_RELOAD);
    wire hit_ccsr = word_idx == (ADDR_WIDTH-2)'(IDX_CAPTURE_CSR);
    wire hit_cap1 = word_idx == (ADDR_WIDTH-2)'(IDX_CAPTURE_1);
    wire hit_cap2 = word_idx == (ADDR_WIDTH-2)'(IDX_CAPTURE_2);
    wire hit_tbc = word_idx == (ADDR_WIDTH-2)'(IDX_TB_COUNT);
    wire hit_tbs = word_idx == (ADDR_WIDTH-2)'(IDX_TB_CSR);
    wire wr_csr = wr_ok & hit_csr;
    wire wr_cnt = wr_ok & hit_cnt;
    wire force_reload = wr_csr & wdata[CSR_FORCE];
    wire rd_csr = rd_ok & hit_csr;
    wire rd_ccsr = rd_ok & hit_ccsr;
    wire rd_tbs = rd_ok & hit_tbs;

    wire [7:0] csr_view = {ext_clock_select, counter_clock_divider, counter_run_enable,
                           1'b0, overflow_irq_enable, overflow_flag}; // RULE4
    wire [7:0] ccsr_view = {2'b00, capture_edge_select, capture_irq_enable, capture_flag};
    wire [7:0] tbs_view = {1'b0, chain_enable, timebase_ovf, timebase_irq_enable,
                           timebase_run_enable, timebase_divider_select};
    wire [7:0] rd_mux = hit_duty1 ? duty[1] :
                        hit_duty0 ? duty[0] :
                        hit_pwm ? pwm_ctrl :
                        hit_csr ? csr_view :
                        hit_cnt ? counter : // RULE7
                        hit_rel ? reload_value :
                        hit_ccsr ? ccsr_view :
                        hit_cap1 ? capture_value[0] :
                        hit_cap2 ? capture_value[1] :
                        hit_tbc ? timebase_count :
                        hit_tbs ? tbs_view : BYTE_ZERO;

    // Read data is frozen in the wait state so read-to-clear drops only what was shown
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= {RD_PAD, BYTE_RESET};
        end else begin
            WB_ACK_O <= bus_req & ~WB_ACK_O;
            if (bus_req & ~WB_ACK_O) begin
                WB_DAT_O <= {RD_PAD, rd_mux};
            end
        end
    end
    wire [7:0] shown = WB_DAT_O[7:0];

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    // A level counts once the second and third stages agree
    wire ext_agree = ext_sync[1] == ext_sync[2];
    wire ext_rise = ext_agree & ext_sync[2] & ~ext_level;

    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            ext_sync <= SYNC_RESET;
            ext_level <= 1'b0;
        end else begin
            ext_sync <= {ext_sync[1:0], EXT_CLOCK_IN}; // RULE27
            if (ext_agree) begin
                ext_level <= ext_sync[2];
            end
        end
    end

    // ----------------------------------------------------------------
    // Auto-reload counter
    // ----------------------------------------------------------------
    wire input_tick = ext_clock_select ? ext_rise : 1'b1; // RULE1
    wire pre_step = counter_run_enable & input_tick; // RULE3
    wire count_tick = pre_step & tap_hit({1'b0, art_pre}, {1'b0, counter_clock_divider}); // RULE2
    wire overflow = count_tick & (counter == BYTE_MAX) & ~wr_cnt & ~force_reload;
    wire [7:0] counter_inc = 8'(counter + BYTE_ONE);
    wire [7:0] next_counter = wr_cnt ? wdata : // RULE7
                              force_reload ? reload_value : // RULE4
                              overflow ? reload_value : // RULE9
                              count_tick ? counter_inc : counter;
    wire [6:0] next_art_pre = (wr_cnt | force_reload) ? ART_PRE_RESET : // RULE8
                              pre_step ? 7'(art_pre + 7'h01) : art_pre;

    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            counter <= BYTE_RESET;
            art_pre <= ART_PRE_RESET;
        end else begin
            counter <= next_counter;
            art_pre <= next_art_pre;
        end
    end

    // Set wins over a read-to-clear in the same cycle
    wire next_overflow_flag = overflow | (overflow_flag & ~(rd_csr & shown[CSR_OVF])); // RULE6

    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            ext_clock_select <= 1'b0;
            counter_clock_divider <= 3'h0;
            counter_run_enable <= 1'b0;
            overflow_irq_enable <= 1'b0;
            overflow_flag <= 1'b0;
        end else begin
            overflow_flag <= next_overflow_flag;
            if (wr_csr) begin
                ext_clock_select <= wdata[CSR_EXT_CLOCK_SELECT];
                counter_clock_divider <= wdata[CSR_CC_HI:CSR_CC_LO];
                counter_run_enable <= wdata[CSR_RUN];
                overflow_irq_enable <= wdata[CSR_OIE];
            end
        end
    end

    // ----------------------------------------------------------------
    // Plain software registers
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            duty[0] <= BYTE_RESET;
            duty[1] <= BYTE_RESET;
            pwm_ctrl <= BYTE_RESET;
            reload_value <= BYTE_RESET;
            capture_edge_select <= 2'h0;
            capture_irq_enable <= 2'h0;
        end else begin
            if (wr_ok & hit_duty0) begin
                duty[0] <= wdata;
            end
            if (wr_ok & hit_duty1) begin
                duty[1] <= wdata;
            end
            if (wr_ok & hit_pwm) begin
                pwm_ctrl <= {2'b00, wdata[PWM_OE_HI:PWM_OE_LO], 2'b00, wdata[PWM_POL_HI:PWM_POL_LO]};
            end
            if (wr_ok & hit_rel) begin
                reload_value <= wdata; // RULE10
            end
            if (wr_ok & hit_ccsr) begin
                capture_edge_select <= wdata[CAP_EDGE_HI:CAP_EDGE_LO];
                capture_irq_enable <= wdata[CAP_IE_HI:CAP_IE_LO];
            end
        end
    end

    // ----------------------------------------------------------------
    // PWM and capture channels
    // ----------------------------------------------------------------
    wire [1:0] pwm_polarity = pwm_ctrl[PWM_POL_HI:PWM_POL_LO];

    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        // Shadow follows duty only at overflow so a mid-period change cannot glitch
        wire [7:0] next_shadow = overflow ? duty[ch] : compare_shadow[ch]; // RULE16
        // Level computed from next state so the overflow edge and the pin move together
        wire base_level = (next_shadow == BYTE_MAX) ? 1'b0 : // RULE14
                          (next_shadow == BYTE_ZERO) ? 1'b1 :
                          (next_counter <= next_shadow); // RULE12 RULE15
        wire next_pwm = base_level ^ pwm_polarity[ch]; // RULE9 RULE13

        wire cap_agree = cap_sync[ch][1] == cap_sync[ch][2];
        wire cap_new = cap_sync[ch][2];
        wire cap_edge = cap_agree & (cap_new != cap_level[ch]) &
                        (cap_new == capture_edge_select[ch]); // RULE17
        wire cap_take = cap_edge & ~capture_flag[ch]; // RULE21
        wire cap_clear = rd_ccsr & shown[CAP_FLAG_LO + ch];

        always_ff @(posedge CLOCK) begin
            if (!NRST) begin
                compare_shadow[ch] <= BYTE_RESET;
                PWM_OUT[ch] <= 1'b0;
                cap_sync[ch] <= SYNC_RESET;
                cap_level[ch] <= 1'b0;
                capture_flag[ch] <= 1'b0;
                capture_value[ch] <= BYTE_RESET;
            end else begin
                compare_shadow[ch] <= next_shadow;
                PWM_OUT[ch] <= next_pwm;
                cap_sync[ch] <= {cap_sync[ch][1:0], CAPTURE_IN[ch]}; // RULE27
                if (cap_agree) begin
                    cap_level[ch] <= cap_new;
                end
                capture_flag[ch] <= cap_edge | (capture_flag[ch] & ~cap_clear); // RULE19
                if (cap_take) begin
                    capture_value[ch] <= counter; // RULE20
                end
            end
        end
    end

    assign PWM_OE = pwm_ctrl[PWM_OE_HI:PWM_OE_LO]; // RULE11

    // ----------------------------------------------------------------
    // Timebase unit
    // ----------------------------------------------------------------
    wire wr_tbs = wr_ok & hit_tbs;
    wire tb_own_tick = tap_hit(tb_pre, 4'({1'b0, timebase_divider_select} + TB_TAP_OFFSET)); // RULE23
    wire tb_tick = timebase_run_enable & (chain_enable ? overflow : tb_own_tick); // RULE22 RULE26
    wire tb_wrap = tb_tick & (timebase_count == BYTE_MAX) & ~(wr_ok & hit_tbc);
    wire [7:0] next_tb_count = (wr_ok & hit_tbc) ? wdata : // RULE25
                               tb_tick ? 8'(timebase_count + BYTE_ONE) : timebase_count;
    // Stopped timebase keeps its count but restarts its prescaler
    wire [7:0] next_tb_pre = timebase_run_enable ? 8'(tb_pre + BYTE_ONE) : BYTE_ZERO;
    wire next_tb_ovf = tb_wrap | (timebase_ovf & ~(rd_tbs & shown[TB_OVF])); // RULE24

    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            timebase_count <= BYTE_RESET;
            tb_pre <= BYTE_RESET;
            timebase_ovf <= 1'b0;
            chain_enable <= 1'b0;
            timebase_irq_enable <= 1'b0;
            timebase_run_enable <= 1'b0;
            timebase_divider_select <= 3'h0;
        end else begin
            timebase_count <= next_tb_count;
            tb_pre <= next_tb_pre;
            timebase_ovf <= next_tb_ovf;
            if (wr_tbs) begin
                chain_enable <= wdata[TB_CHAIN];
                timebase_irq_enable <= wdata[TB_ITE];
                timebase_run_enable <= wdata[TB_RUN];
                timebase_divider_select <= wdata[TB_PR_HI:TB_PR_LO];
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupt requests
    // ----------------------------------------------------------------
    assign ART_IRQ = (overflow_flag & overflow_irq_enable) | // RULE5
                     |(capture_flag & capture_irq_enable); // RULE18
    assign TB_IRQ = timebase_ovf & timebase_irq_enable; // RULE24

endmodule

`default_nettype wire

// *** sim/art_timer_sva.sv ***
// Bus and output timing checks for the auto-reload PWM timer
`timescale 1ns/1ps
`default_nettype none
module art_timer_sva
    import art_pkg::*;
#(
    parameter int ADDR_WIDTH = 8
) (
    input wire logic CLOCK,
    input wire logic NRST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [ADDR_WIDTH-1:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    input wire logic EXT_CLOCK_IN,
    input wire logic [1:0] CAPTURE_IN,
    input wire logic [1:0] PWM_OUT,
    input wire logic [1:0] PWM_OE,
    input wire logic ART_IRQ,
    input wire logic TB_IRQ
);
    // ----------------------------------------------------------------
    // Decodes
    // ----------------------------------------------------------------
    wire logic req = WB_CYC_I && WB_STB_I;
    wire logic hit_csr = (WB_ADR_I == ADDR_WIDTH'(IDX_TIMER_CSR << 2));
    wire logic hit_pwm = (WB_ADR_I == ADDR_WIDTH'(IDX_PWM_CTRL << 2));
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!NRST);
    AST_ACK_RESP: assert property (req && !WB_ACK_O |=> WB_ACK_O) else $error("ack missing after request");
    AST_ACK_PULSE: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack longer than one cycle");
    AST_ACK_CAUSE: assert property (WB_ACK_O |-> $past(req)) else $error("ack without request");
    AST_RD_PAD: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h000000) else $error("upper read bits set");
    AST_FORCE_RD0: assert property (WB_ACK_O && !WB_WE_I && hit_csr |-> !WB_DAT_O[CSR_FORCE])
        else $error("force reload bit read as one");
    AST_OE_CAUSE: assert property ($changed(PWM_OE) |-> $past(WB_ACK_O && WB_WE_I && hit_pwm && WB_SEL_I[0]))
        else $error("pin enable changed without control write");
    AST_ART_IRQ_FALL: assert property ($fell(ART_IRQ) |-> $past(WB_ACK_O))
        else $error("timer request dropped without bus access");
    AST_TB_IRQ_FALL: assert property ($fell(TB_IRQ) |-> $past(WB_ACK_O))
        else $error("timebase request dropped without bus access");
    COV_WRITE: cover property (WB_ACK_O && WB_WE_I);
    COV_ART_IRQ: cover property ($rose(ART_IRQ));
    COV_TB_IRQ: cover property ($rose(TB_IRQ));
endmodule
bind art_timer art_timer_sva #(.ADDR_WIDTH(ADDR_WIDTH)) u_sva (.CLOCK(CLOCK), .NRST(NRST), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
    .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .EXT_CLOCK_IN(EXT_CLOCK_IN), .CAPTURE_IN(CAPTURE_IN),
    .PWM_OUT(PWM_OUT), .PWM_OE(PWM_OE), .ART_IRQ(ART_IRQ), .TB_IRQ(TB_IRQ));
`default_nettype wire

// *** sim/art_tb.sv ***
// Self-checking testbench of the auto-reload PWM timer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_total++; \
    $display("MISMATCH t=%0t got %0h expected %0h", $time, a, b); end end
module tb
    import art_pkg::*;
;
    logic CLOCK = 1'b0, NRST = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ext = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h00000000, rdat;
    logic ack, art_irq, tb_irq;
    logic [1:0] cap = 2'b10, pwm, oe;
    int err_total = 0, comparisons = 0;
    art_timer #(.ADDR_WIDTH(8)) DUT (.CLOCK(CLOCK), .NRST(NRST), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .EXT_CLOCK_IN(ext), .CAPTURE_IN(cap), .PWM_OUT(pwm), .PWM_OE(oe), .ART_IRQ(art_irq), .TB_IRQ(tb_irq));
    initial begin
        forever #5 CLOCK = ~CLOCK;
    end
    function automatic logic [7:0] ba(input logic [7:0] i);
        return i << 2;
    endfunction
    // ----------------------------------------------------------------
    // Bus tasks: request held until ack is sampled at a rising edge
    // ----------------------------------------------------------------
    // No local limit: a missing ack is caught by the watchdog, which ends the run
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge CLOCK);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'hF; wdat <= {24'h000000, d};
        do begin
            @(posedge CLOCK);
        end while (ack !== 1'b1);
        q = rdat[7:0];
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        logic [7:0] q;
        xfer(1'b1, ba(i), d, q);
    endtask
    task automatic rd(input logic [7:0] i, output logic [7:0] q);
        xfer(1'b0, ba(i), 8'h00, q);
    endtask
    task automatic rc(input logic [7:0] i, input logic [7:0] e);
        logic [7:0] q;
        rd(i, q);
        `CHK(q, e)
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset_values();
        logic [7:0] q;
        `CHK(oe, 2'b00)
        for (int i = 8'h14; i <= 8'h1E; i++) rc(8'(i), 8'h00);
        xfer(1'b0, 8'h7C, 8'h00, q);
        `CHK(q, 8'h00)
    endtask
    task automatic t_counter_rate();
        wr(IDX_COUNTER, 8'h10);
        repeat (20) @(posedge CLOCK);
        rc(IDX_COUNTER, 8'h10);
        wr(IDX_TIMER_CSR, 8'h78);
        wr(IDX_COUNTER, 8'h20);
        repeat (100) @(posedge CLOCK);
        rc(IDX_COUNTER, 8'h20);
        repeat (100) @(posedge CLOCK);
        rc(IDX_COUNTER, 8'h21);
        wr(IDX_TIMER_CSR, 8'h00);
    endtask
    task automatic t_overflow();
        logic [7:0] q;
        wr(IDX_RELOAD, 8'hF0);
        wr(IDX_TIMER_CSR, 8'h0E);
        repeat (40) @(posedge CLOCK);
        `CHK(art_irq, 1'b1)
        wr(IDX_TIMER_CSR, 8'h02);
        rc(IDX_TIMER_CSR, 8'h03);
        // Read-to-clear lands on the ack edge; look one edge later
        @(posedge CLOCK);
        `CHK(art_irq, 1'b0)
        rc(IDX_TIMER_CSR, 8'h02);
        rd(IDX_COUNTER, q);
        `CHK(q[7:4], 4'hF)
        wr(IDX_TIMER_CSR, 8'h08);
        repeat (40) @(posedge CLOCK);
        `CHK(art_irq, 1'b0)
        wr(IDX_TIMER_CSR, 8'h00);
        rc(IDX_TIMER_CSR, 8'h01);
    endtask
    task automatic t_pwm();
        logic [8:0] h0, h1;
        h0 = 9'h000;
        h1 = 9'h000;
        wr(IDX_RELOAD, 8'h00);
        wr(IDX_DUTY_CH0, 8'h80);
        wr(IDX_DUTY_CH1, 8'hFF);
        wr(IDX_PWM_CTRL, 8'h30);
        @(posedge CLOCK);
        `CHK(oe, 2'b11)
        wr(IDX_COUNTER, 8'h00);
        wr(IDX_TIMER_CSR, 8'h08);
        // Shadows only take the duty values at the first overflow
        repeat (300) @(posedge CLOCK);
        repeat (256) begin
            @(posedge CLOCK);
            h0 += 9'(pwm[0]);
            h1 += 9'(pwm[1]);
        end
        `CHK(h0, 9'h081)
        `CHK(h1, 9'h000)
        wr(IDX_PWM_CTRL, 8'h32);
        repeat (3) @(posedge CLOCK);
        `CHK(pwm[1], 1'b1)
        wr(IDX_PWM_CTRL, 8'h12);
        @(posedge CLOCK);
        `CHK(oe, 2'b01)
    endtask
    task automatic t_capture();
        wr(IDX_TIMER_CSR, 8'h00);
        wr(IDX_COUNTER, 8'h55);
        wr(IDX_CAPTURE_CSR, 8'h1C);
        cap[0] <= 1'b1;
        repeat (8) @(posedge CLOCK);
        `CHK(art_irq, 1'b1)
        wr(IDX_COUNTER, 8'h66);
        cap[0] <= 1'b0;
        repeat (8) @(posedge CLOCK);
        cap[0] <= 1'b1;
        cap[1] <= 1'b0;
        repeat (8) @(posedge CLOCK);
        rc(IDX_CAPTURE_1, 8'h55);
        rc(IDX_CAPTURE_2, 8'h66);
        rc(IDX_CAPTURE_CSR, 8'h1F);
        @(posedge CLOCK);
        `CHK(art_irq, 1'b0)
        cap[1] <= 1'b1;
        repeat (8) @(posedge CLOCK);
        rc(IDX_CAPTURE_CSR, 8'h1C);
    endtask
    task automatic t_ext_clock();
        wr(IDX_COUNTER, 8'h00);
        wr(IDX_TIMER_CSR, 8'h88);
        repeat (5) begin
            ext <= 1'b1;
            repeat (4) @(posedge CLOCK);
            ext <= 1'b0;
            repeat (4) @(posedge CLOCK);
        end
        repeat (10) @(posedge CLOCK);
        wr(IDX_TIMER_CSR, 8'h00);
        rc(IDX_COUNTER, 8'h05);
    endtask
    task automatic t_timebase();
        wr(IDX_TB_COUNT, 8'hF0);
        wr(IDX_TB_CSR, 8'h18);
        repeat (50) @(posedge CLOCK);
        `CHK(tb_irq, 1'b1)
        wr(IDX_TB_CSR, 8'h10);
        rc(IDX_TB_CSR, 8'h30);
        @(posedge CLOCK);
        `CHK(tb_irq, 1'b0)
        wr(IDX_TB_COUNT, 8'h00);
        wr(IDX_TB_CSR, 8'h0F);
        repeat (600) @(posedge CLOCK);
        wr(IDX_TB_CSR, 8'h07);
        rc(IDX_TB_COUNT, 8'h02);
    endtask
    task automatic t_chain();
        wr(IDX_RELOAD, 8'hFF);
        wr(IDX_TB_COUNT, 8'h10);
        wr(IDX_TB_CSR, 8'h48);
        wr(IDX_COUNTER, 8'hFF);
        wr(IDX_TIMER_CSR, 8'h78);
        repeat (200) @(posedge CLOCK);
        wr(IDX_TIMER_CSR, 8'h00);
        rc(IDX_TB_COUNT, 8'h11);
        wr(IDX_TB_CSR, 8'h00);
    endtask
    task automatic complete_run();
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge CLOCK);
        NRST <= 1'b1;
        t_reset_values();
        t_counter_rate();
        t_overflow();
        t_pwm();
        t_capture();
        t_ext_clock();
        t_timebase();
        t_chain();
        complete_run();
    end
    // Whole sequence needs well under 10,000 cycles
    initial begin
        #200000;
        $display("MISMATCH t=%0t watchdog timeout", $time);
        err_total++;
        complete_run();
    end
endmodule
`default_nettype wire
